// file: bench/ila_core_model.sv
// Behavioural core answering grants
`timescale 1ns/1ps
module ila_core_model (
   input  wire logic       clock,      // Bus clock
   input  wire logic       rstn,       // Async reset
   input  wire logic       take,       // Grant strobe
   input  wire logic       hold_mask,  // Bench holds mask set
   input  wire logic       no_fetch,   // Bench withholds the fetch
   input  wire logic [3:0] dly,        // Stack cycles, prompt or slow
   output logic            imask,      // Global mask bit
   output logic            vec_fetched // Vector fetched pulse
);
   logic [4:0] cnt_r;
   logic       imask_r;
   // stack then vector fetch
   // Withheld fetch leaves the mask clear as the only release
   assign vec_fetched = (cnt_r == 5'h05) && !no_fetch;
   assign imask       = imask_r | hold_mask;
   // mask on entry, cleared by return
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_r   <= 5'h00;
         imask_r <= 1'b0;
      end
      else if (take)
      begin
         cnt_r   <= {1'b0, dly} + 5'h06;
         imask_r <= 1'b1;
      end
      else if (cnt_r != 5'h00)
      begin
         cnt_r   <= cnt_r - 5'h01;
         imask_r <= (cnt_r != 5'h01);
      end
   end
endmodule : ila_core_model

// file: bench/test_ila_latch_arb.sv
// Self-checking bench for the latch and arbitration
`timescale 1ns/1ps
module test_ila_latch_arb;
   import ila_pkg::*;
   logic        clock = 1'b0, rstn = 1'b0;
   logic [15:0] irq_req = '0, irq_en = '0, rnd = 16'h0029;
   logic        ins = 1'b0, sw = 1'b0, hm = 1'b0, imask, vf, busy;
   logic [3:0]  dly = 4'h1;
   logic        nf = 1'b0;
   ila_core_t   core;
   ila_grant_t  grant;
   int          mismatches = 0, samples_checked = 0;
   assign core = '{ins, imask, sw, vf};
   ila_latch_arb u_dut (.clock(clock), .rstn(rstn), .irq_req(irq_req),
      .irq_en(irq_en), .core(core), .grant(grant), .busy(busy));
   ila_core_model u_core (.clock(clock), .rstn(rstn), .take(grant.take),
      .hold_mask(hm), .no_fetch(nf), .dly(dly), .imask(imask),
      .vec_fetched(vf));
   // *********************
   // Expectation and checks
   // *********************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   // Trap first, then lowest enabled index
   function automatic logic [4:0] exp_code(input logic [15:0] r, e,
      input logic d, s, m);
      if (d && s)
         return CODE_SWTRAP;
      if (!d || m)
         return CODE_NONE;
      for (int i = 0; i < 16; i++)
         if (r[i] && e[i])
            return CODE_HW_BASE + 5'(i);
      return CODE_NONE;
   endfunction : exp_code
   task automatic chk(input logic [4:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   // One offer, then a higher request tries to displace it
   task automatic trial(input logic [15:0] r, e, input logic d, s, m);
      logic [4:0] c;
      logic       t;
      int         n;
      c = exp_code(r, e, d, s, m);
      t = (c != CODE_NONE);
      @(negedge clock);
      {irq_req, irq_en, ins, sw, hm} = {r, e, d, s, m};
      @(negedge clock);
      sw = 1'b0;
      ins = t;
      chk({4'h0, grant.take}, {4'h0, t});
      chk(grant.code, c);
      irq_req = r | 16'h0001;
      irq_en = 16'hffff;
      @(negedge clock);
      {ins, hm, irq_req} = '0;
      chk(grant.code, c);
      chk({4'h0, busy}, {4'h0, t});
      n = 0;
      while ((busy !== 1'b0 || imask !== 1'b0) && n < 60)
      begin
         @(negedge clock);
         n++;
      end
      chk({4'h0, n == 60}, 5'h00);
      $display("trial done, code %h", c);
   endtask : trial
   initial
   begin
      forever #2 clock = ~clock;
   end
   // Watchdog well beyond the longest run
   initial
   begin
      #40000;
      mismatches++;
      test_done;
   end
   initial
   begin
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      trial(16'h8000, 16'hffff, 1, 0, 0);
      trial(16'h00f0, 16'hff0f, 1, 0, 0);
      trial(16'h0004, 16'hffff, 0, 0, 0);
      trial(16'h0004, 16'hffff, 1, 0, 1);
      trial(16'h0004, 16'hffff, 1, 1, 1);
      // Fetch withheld: only the falling mask frees the claim
      nf = 1'b1;
      trial(16'h0300, 16'hffff, 1, 0, 0);
      nf = 1'b0;
      // Reset in the middle of a claim clears it
      @(negedge clock);
      {irq_req, irq_en, ins} = {16'h0002, 16'hffff, 1'b1};
      @(negedge clock);
      chk({4'h0, grant.take}, 5'h01);
      {ins, irq_req} = '0;
      rstn = 1'b0;
      @(negedge clock);
      chk(grant.code, CODE_NONE);
      chk({4'h0, busy}, 5'h00);
      rstn = 1'b1;
      $display("reset test done");
      repeat (30)
      begin
         rnd = lfsr(rnd);
         dly = rnd[3:0];
         trial(rnd, lfsr(rnd), rnd[4] | rnd[5], &rnd[2:0], rnd[6] & rnd[7]);
      end
      test_done;
   end
endmodule : test_ila_latch_arb

// file: design/ila_latch_arb.sv
// Interrupt latch and arbitration inside the system_integration_unit
// Summary of operation
// RULE_01: Core stacks its registers before running any handler code.
// RULE_02: Core sets the global mask on entry to service.
// RULE_03: return_from_irq_instr restores stacked registers and resumes.
// RULE_04: Requests latched and arbitrated at processing start, not always.
// RULE_05: Arbitration result is a fixed code selecting the vector.
// RULE_06: A latched request is never displaced, even by higher priority.
// RULE_07: Claim holds until serviced or global mask cleared. A trap claim here waits for its fetch.
// RULE_08: Pending requests checked only once an instruction completes.
// RULE_09: Hardware request taken only if unmasked and source enabled.
// RULE_10: Highest priority pending request is serviced first.
// RULE_11: software_trap_instr triggers processing regardless of the mask.
// RULE_12: Entry: dummy, stack writes downward, vector high then low.
`timescale 1ns/1ps
module ila_latch_arb
   import ila_pkg::*;
#(
   parameter int N_SRC = ila_pkg::NUM_SRC
) (
   input  wire logic             clock,     // Bus clock
   input  wire logic             rstn,      // Async reset, active low
   input  wire logic [N_SRC-1:0] irq_req,   // Peripheral requests, level
   input  wire logic [N_SRC-1:0] irq_en,    // Per-source enable bits
   input  wire ila_pkg::ila_core_t core,    // Core status
   output ila_pkg::ila_grant_t   grant,     // Take strobe and code
   output logic                  busy       // A request holds its claim
);
   import ila_pkg::*;

   // ************************************************************
   // Request qualification and arbitration
   // ************************************************************
   ila_state_t        state_r, state_nxt;
   logic [CODE_W-1:0] code_r, code_nxt;
   logic              take_r, take_nxt;
   logic [N_SRC-1:0]  qual_req;
   logic              hw_any;
   logic [CODE_W-1:0] hw_idx;
   logic              check_pt;
   logic              hw_ok;
   logic              sw_ok;
   logic              mask_prev_r;
   logic              mask_fell;

   // RULE_09 enable gate; the mask gates hw_ok below
   assign qual_req = irq_req & irq_en;
   // RULE_08 only at instruction boundary
   assign check_pt = core.instr_done && (state_r == ILA_IDLE);
   assign hw_ok    = check_pt && hw_any && !core.imask;
   // RULE_11 trap ignores the mask
   assign sw_ok    = check_pt && core.swtrap;

   // RULE_07 a falling mask, not a low one, frees a hardware claim; a mask still low
   // right after the take only means the core has not set it yet
   assign mask_fell = mask_prev_r && !core.imask;

   // RULE_10 fixed priority choice
   ila_prio_enc #(
      .N (N_SRC),
      .W (CODE_W)
   ) u_enc (
      .req (qual_req),
      .any (hw_any),
      .idx (hw_idx)
   );

   // ************************************************************
   // Latch state machine
   // ************************************************************
   // Code is frozen once latched so nothing can overtake it
   always_comb
   begin
      state_nxt = state_r;
      code_nxt  = code_r;
      take_nxt  = 1'b0;
      case (state_r)
         ILA_IDLE:
         begin
            // RULE_04 latch and arbitrate at start
            if (sw_ok)
            begin
               state_nxt = ILA_LATCHED;
               code_nxt  = CODE_SWTRAP;
               take_nxt  = 1'b1;
            end
            else if (hw_ok)
            begin
               state_nxt = ILA_LATCHED;
               // RULE_05 fixed code per source
               code_nxt  = hw_idx + CODE_HW_BASE;
               take_nxt  = 1'b1;
            end
         end
         ILA_LATCHED:
         begin
            // RULE_06 no displacement while latched
            // RULE_07 release on service, or on mask clear for hardware claims only
            if (core.vec_fetched)
               state_nxt = ILA_SERVICE;
            else if (mask_fell && code_r != CODE_SWTRAP)
            begin
               state_nxt = ILA_IDLE;
               code_nxt  = CODE_NONE;
            end
         end
         ILA_SERVICE:
         begin
            // Serviced: arbitration may admit the next request
            state_nxt = ILA_IDLE;
            code_nxt  = CODE_NONE;
         end
         default:
         begin
            state_nxt = ILA_IDLE;
            code_nxt  = CODE_NONE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ILA_IDLE;
         code_r  <= CODE_NONE;
         take_r  <= 1'b0;
         mask_prev_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         code_r  <= code_nxt;
         take_r  <= take_nxt;
         mask_prev_r <= core.imask;
      end
   end

   // Take and code straight from flops, busy decoded from state_r
   assign grant.take = take_r;
   assign grant.code = code_r;
   assign busy       = (state_r != ILA_IDLE);

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_idle_hw;
      (state_r == ILA_IDLE) && core.instr_done && !core.swtrap
         && !core.imask && |(irq_req & irq_en);
   endsequence

   sequence s_take;
      grant.take && (grant.code != CODE_NONE);
   endsequence

   // Hardware claim sees the mask fall before any vector fetch
   sequence s_mask_fell;
      (state_r == ILA_LATCHED) && !core.vec_fetched
         && $fell(core.imask) && (code_r != CODE_SWTRAP);
   endsequence

   // RULE_04 take only follows a boundary
   take_cause_a: assert property ( // RULE_04
      grant.take |-> $past(core.instr_done))
      else $error("take without instruction boundary");

   // RULE_05 boundary hardware request gets a take with a code
   take_code_a: assert property ( // RULE_05
      s_idle_hw |=> s_take)
      else $error("hardware request not granted with a code");

   // RULE_06 code held while latched
   code_hold_a: assert property ( // RULE_06
      (state_r == ILA_LATCHED) && !core.vec_fetched && core.imask
      |=> $stable(code_r))
      else $error("latched code displaced");

   // RULE_07 mask clear releases claim
   mask_release_a: assert property ( // RULE_07
      s_mask_fell |=> !busy)
      else $error("claim not released on mask clear");

   // RULE_08 nothing taken mid instruction
   no_mid_a: assert property ( // RULE_08
      !core.instr_done |=> !grant.take)
      else $error("take in middle of instruction");

   // RULE_09 masked request is ignored
   masked_ign_a: assert property ( // RULE_09
      core.imask && !core.swtrap |=> !grant.take)
      else $error("masked request taken");

   // RULE_10 highest priority code
   top_prio_a: assert property ( // RULE_10
      (s_idle_hw and qual_req[0]) |=> grant.code == CODE_HW_BASE)
      else $error("highest priority not chosen");

   // RULE_11 trap despite mask
   trap_take_a: assert property ( // RULE_11
      (state_r == ILA_IDLE) && core.instr_done && core.swtrap
      |=> grant.take && grant.code == CODE_SWTRAP)
      else $error("software trap not taken");

   // Service completes within two cycles
   svc_done_a: assert property ( // RULE_07
      (state_r == ILA_LATCHED) && core.vec_fetched |=> ##1 !busy)
      else $error("claim not freed after service");

   // RULE_04 take lasts a single cycle
   take_pulse_a: assert property ( // RULE_04
      grant.take |=> !grant.take)
      else $error("take longer than one cycle");

   // RULE_07 claim stands while take is shown
   busy_take_a: assert property ( // RULE_07
      grant.take |-> busy)
      else $error("take without a claim");

   // RULE_11 trap claim waits for its fetch
   trap_hold_a: assert property ( // RULE_11
      (state_r == ILA_LATCHED) && (code_r == CODE_SWTRAP)
      && !core.vec_fetched |=> busy)
      else $error("trap claim dropped before service");
endmodule : ila_latch_arb

// file: design/ila_pkg.sv
// Package of types and constants for the interrupt latch and arbitration
package ila_pkg;
   // Number of maskable hardware request sources
   localparam int NUM_SRC = 16;
   // Width of the vector code presented to the core
   localparam int CODE_W = 5;
   // Code meaning no request latched
   localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
   // Code for the software trap, above every hardware source
   localparam logic [CODE_W-1:0] CODE_SWTRAP = 5'h01;
   // Hardware source n gets code n + CODE_HW_BASE
   localparam logic [CODE_W-1:0] CODE_HW_BASE = 5'h02;

   // Latch state machine
   typedef enum logic [1:0] {
      ILA_IDLE    = 2'b00,
      ILA_LATCHED = 2'b01,
      ILA_SERVICE = 2'b10
   } ila_state_t;

   // Status of the core as seen by the block
   typedef struct packed {
      logic instr_done;    // Current instruction has completed
      logic imask;         // Global interrupt mask bit
      logic swtrap;        // Software trap instruction completing
      logic vec_fetched;   // Core has fetched the vector (serviced)
   } ila_core_t;

   // Answer to the core
   typedef struct packed {
      logic              take;   // Start interrupt processing
      logic [CODE_W-1:0] code;   // Arbitration result
   } ila_grant_t;
endpackage : ila_pkg

// file: design/ila_prio_enc.sv
// Fixed priority encoder: lowest index wins
`timescale 1ns/1ps
module ila_prio_enc #(
   parameter int N = 16,
   parameter int W = 5
) (
   input  wire logic [N-1:0] req,      // Request vector
   output logic             any,       // At least one request
   output logic [W-1:0]     idx        // Index of the winner
);
   // Scan from the lowest priority up so the highest wins last
   always_comb
   begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            any = 1'b1;
            idx = W'(i);
         end
      end
   end
endmodule : ila_prio_enc
